// *** logic/debug_mailbox_pkg.sv ***
/*
  Constants, register map and carrier types for the debug mailbox with its
  dual-key unlock. Assumes one system clock shared by both register ports.
*/
// Contract
// RQ1: Debugger port offers a read-only identification word at 0x0FC.
// RQ2: Writing an outbound word marks that sender's outbound flag as waiting.
// RQ3: Reading an inbound word marks that reader's inbound flag as consumed.
// RQ4: Debugger word written at 0x020 is read by the CPU at 0x400.
// RQ5: CPU word written at 0x480 is read by the debugger at 0x028.
// RQ6: Both sides have flags telling whether each direction's word is unread.
// RQ7: Key write lock resets to 0; writing 1 makes the CPU key read-only.
// RQ8: Once set, the lock ignores writes and holds until reset.
// RQ9: Full wipe starts only when both keys are equal and non-zero.
// RQ10: A sender's write also marks the receiver's inbound flag as waiting.
// RQ11: A receiver's read also returns the sender's outbound flag to consumed.
// RQ12: Debugger and CPU firmware both write the same non-zero key to unlock.
// RQ13: Mailbox flags sit in bit 0, one meaning waiting; other bits zero.
package debug_mailbox_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Debugger side, reached through the control access port.
  localparam logic [ADDR_W-1:0] DBG_UNLOCK_KEY_OFS    = 12'h01C;
  localparam logic [ADDR_W-1:0] DBG_OUTBOUND_WORD_OFS = 12'h020;
  localparam logic [ADDR_W-1:0] DBG_OUTBOUND_FLAG_OFS = 12'h024;
  localparam logic [ADDR_W-1:0] DBG_INBOUND_WORD_OFS  = 12'h028;
  localparam logic [ADDR_W-1:0] DBG_INBOUND_FLAG_OFS  = 12'h02C;
  localparam logic [ADDR_W-1:0] PORT_IDENT_OFS        = 12'h0FC;

  // CPU side, the peripheral mirror.
  localparam logic [ADDR_W-1:0] CPU_INBOUND_WORD_OFS  = 12'h400;
  localparam logic [ADDR_W-1:0] CPU_INBOUND_FLAG_OFS  = 12'h404;
  localparam logic [ADDR_W-1:0] CPU_OUTBOUND_WORD_OFS = 12'h480;
  localparam logic [ADDR_W-1:0] CPU_OUTBOUND_FLAG_OFS = 12'h484;
  localparam logic [ADDR_W-1:0] CPU_KEY_LOCK_OFS      = 12'h500;
  localparam logic [ADDR_W-1:0] CPU_UNLOCK_KEY_OFS    = 12'h504;

  localparam int LOCK_BIT = 0;
  localparam int FLAG_BIT = 0;

  localparam logic [DATA_W-1:0] WORD_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] KEY_RESET  = 32'h00000000;
  localparam logic [DATA_W-1:0] READ_ZERO  = 32'h00000000;

  // Identification word; the value is arbitrary.
  localparam logic [DATA_W-1:0] PORT_IDENT_VALUE = 32'h0A5A0001;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } reg_rsp_t;

endpackage : debug_mailbox_pkg

// *** logic/debug_mailbox_erase_unlock.sv ***
/*
  Mailbox between an external debugger and the on-chip CPU, with the
  dual-key unlock that requests a full wipe. Assumes the debug access
  port decodes its serial link into single-cycle requests on mclk and that
  the wipe sequencer acts on the one-cycle start pulse.
*/
`timescale 1ns/1ps
module debug_mailbox_erase_unlock (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire debug_mailbox_pkg::reg_req_t   dbg_req,
  output      debug_mailbox_pkg::reg_rsp_t   dbg_rsp,
  input  wire debug_mailbox_pkg::reg_req_t   cpu_req,
  output      debug_mailbox_pkg::reg_rsp_t   cpu_rsp,
  output      logic                          full_wipe_start,
  output      logic                          key_write_lock
);
  import debug_mailbox_pkg::*;

  logic [DATA_W-1:0] dbg_unlock_key;
  logic [DATA_W-1:0] cpu_unlock_key;
  logic [DATA_W-1:0] d2c_word;
  logic [DATA_W-1:0] c2d_word;
  logic              d2c_waiting;
  logic              c2d_waiting;
  logic              match_seen;
  logic [DATA_W-1:0] next_dbg_data;
  logic [DATA_W-1:0] next_cpu_data;

  wire dbg_wr_key  = dbg_req.wr && (dbg_req.addr == DBG_UNLOCK_KEY_OFS);
  wire dbg_wr_word = dbg_req.wr && (dbg_req.addr == DBG_OUTBOUND_WORD_OFS);
  wire dbg_rd_word = dbg_req.rd && (dbg_req.addr == DBG_INBOUND_WORD_OFS);
  wire cpu_wr_word = cpu_req.wr && (cpu_req.addr == CPU_OUTBOUND_WORD_OFS);
  wire cpu_rd_word = cpu_req.rd && (cpu_req.addr == CPU_INBOUND_WORD_OFS);
  wire cpu_wr_lock = cpu_req.wr && (cpu_req.addr == CPU_KEY_LOCK_OFS);
  wire cpu_wr_key  = cpu_req.wr && (cpu_req.addr == CPU_UNLOCK_KEY_OFS);

  wire lock_request = cpu_wr_lock && cpu_req.wdata[LOCK_BIT];
  wire cpu_key_open = cpu_wr_key && !key_write_lock;
  wire keys_match   = (dbg_unlock_key == cpu_unlock_key) && (dbg_unlock_key != KEY_RESET);

  wire [DATA_W-1:0] d2c_flag_word = {{(DATA_W-1){1'b0}}, d2c_waiting};
  wire [DATA_W-1:0] c2d_flag_word = {{(DATA_W-1){1'b0}}, c2d_waiting};
  wire [DATA_W-1:0] lock_word     = {{(DATA_W-1){1'b0}}, key_write_lock};

  // Unmapped offsets read as zero.
  always_comb begin
    case (dbg_req.addr)
      DBG_UNLOCK_KEY_OFS:    next_dbg_data = dbg_unlock_key;
      DBG_OUTBOUND_WORD_OFS: next_dbg_data = d2c_word;
      DBG_OUTBOUND_FLAG_OFS: next_dbg_data = d2c_flag_word; // RQ6 RQ13
      DBG_INBOUND_WORD_OFS:  next_dbg_data = c2d_word; // RQ5
      DBG_INBOUND_FLAG_OFS:  next_dbg_data = c2d_flag_word; // RQ6 RQ13
      PORT_IDENT_OFS:        next_dbg_data = PORT_IDENT_VALUE; // RQ1
      default:               next_dbg_data = READ_ZERO;
    endcase
  end

  always_comb begin
    case (cpu_req.addr)
      CPU_INBOUND_WORD_OFS:  next_cpu_data = d2c_word; // RQ4
      CPU_INBOUND_FLAG_OFS:  next_cpu_data = d2c_flag_word; // RQ6 RQ13
      CPU_OUTBOUND_WORD_OFS: next_cpu_data = c2d_word;
      CPU_OUTBOUND_FLAG_OFS: next_cpu_data = c2d_flag_word; // RQ6 RQ13
      CPU_KEY_LOCK_OFS:      next_cpu_data = lock_word;
      CPU_UNLOCK_KEY_OFS:    next_cpu_data = cpu_unlock_key;
      default:               next_cpu_data = READ_ZERO;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dbg_rsp <= '0;
      cpu_rsp <= '0;
    end else begin
      dbg_rsp.valid <= dbg_req.rd;
      cpu_rsp.valid <= cpu_req.rd;
      if (dbg_req.rd) begin
        dbg_rsp.data <= next_dbg_data;
      end
      if (cpu_req.rd) begin
        cpu_rsp.data <= next_cpu_data;
      end
    end
  end

  // Word storage for each direction.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      d2c_word <= WORD_RESET;
      c2d_word <= WORD_RESET;
    end else begin
      if (dbg_wr_word) begin
        d2c_word <= dbg_req.wdata; // RQ4
      end
      if (cpu_wr_word) begin
        c2d_word <= cpu_req.wdata; // RQ5
      end
    end
  end

  // One flag per direction serves both sides; a write in the same cycle as
  // the consuming read leaves the flag set, so the new word is not lost.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      d2c_waiting <= 1'b0;
      c2d_waiting <= 1'b0;
    end else begin
      if (dbg_wr_word) begin
        d2c_waiting <= 1'b1; // RQ2 RQ10
      end else if (cpu_rd_word) begin
        d2c_waiting <= 1'b0; // RQ3 RQ11
      end
      if (cpu_wr_word) begin
        c2d_waiting <= 1'b1; // RQ2 RQ10
      end else if (dbg_rd_word) begin
        c2d_waiting <= 1'b0; // RQ3 RQ11
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      key_write_lock <= 1'b0; // RQ7
    end else if (lock_request) begin
      key_write_lock <= 1'b1; // RQ7 RQ8
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dbg_unlock_key <= KEY_RESET;
      cpu_unlock_key <= KEY_RESET;
    end else begin
      if (dbg_wr_key) begin
        dbg_unlock_key <= dbg_req.wdata; // RQ12
      end
      if (cpu_key_open) begin
        cpu_unlock_key <= cpu_req.wdata; // RQ7 RQ12
      end
    end
  end

  // The wipe request is a single pulse when the keys first come to match.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      match_seen      <= 1'b0;
      full_wipe_start <= 1'b0;
    end else begin
      match_seen      <= keys_match;
      full_wipe_start <= keys_match && !match_seen; // RQ9
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_dbg_send;
    dbg_wr_word;
  endsequence

  sequence s_cpu_send;
    cpu_wr_word;
  endsequence

  sequence s_cpu_fetch;
    cpu_rd_word && !dbg_wr_word;
  endsequence

  sequence s_dbg_fetch;
    dbg_rd_word && !cpu_wr_word;
  endsequence

  chk_dbg_send_waits: assert property (s_dbg_send |=> d2c_waiting) // RQ2
    else $error("debugger send did not mark its word waiting");

  chk_cpu_send_waits: assert property (s_cpu_send |=> c2d_waiting) // RQ10
    else $error("CPU send did not mark its word waiting");

  chk_fetch_consumes: assert property (s_cpu_fetch |=> !d2c_waiting) // RQ3
    else $error("CPU fetch did not mark the word consumed");

  chk_dbg_fetch_clears: assert property (s_dbg_fetch |=> !c2d_waiting) // RQ11
    else $error("debugger fetch did not mark the word consumed");

  chk_word_to_cpu: assert property (
    (s_dbg_send ##1 (cpu_rd_word && !dbg_wr_word)) |=>
      (cpu_rsp.valid && cpu_rsp.data == $past(dbg_req.wdata, 2))) // RQ4
    else $error("debugger word did not reach the CPU");

  chk_word_to_dbg: assert property (
    (s_cpu_send ##1 (dbg_rd_word && !cpu_wr_word)) |=>
      (dbg_rsp.valid && dbg_rsp.data == $past(cpu_req.wdata, 2))) // RQ5
    else $error("CPU word did not reach the debugger");

  chk_flag_reads_bit: assert property (
    (dbg_req.rd && dbg_req.addr == DBG_OUTBOUND_FLAG_OFS) |=>
      (dbg_rsp.data == {{(DATA_W-1){1'b0}}, $past(d2c_waiting)})) // RQ6
    else $error("debugger outbound flag read is wrong");

  chk_lock_holds: assert property (key_write_lock |=> key_write_lock) // RQ8
    else $error("key write lock dropped before reset");

  chk_key_guarded: assert property (
    (key_write_lock && cpu_wr_key) |=> $stable(cpu_unlock_key)) // RQ7
    else $error("locked CPU key changed");

  chk_wipe_cause: assert property (
    $rose(full_wipe_start) |-> $past(keys_match) && !$past(match_seen)) // RQ9
    else $error("wipe started without matching keys");

  chk_ident_read: assert property (
    (dbg_req.rd && dbg_req.addr == PORT_IDENT_OFS) |=>
      (dbg_rsp.data == PORT_IDENT_VALUE)) // RQ1
    else $error("identification read is wrong");

  chk_cpu_flag_bits: assert property (
    (cpu_req.rd && cpu_req.addr == CPU_OUTBOUND_FLAG_OFS) |=>
      (cpu_rsp.data[DATA_W-1:1] == '0)) // RQ13
    else $error("CPU flag read has upper bits set");

endmodule : debug_mailbox_erase_unlock

// *** testbench/debugger_model.sv ***
/*
  Behavioural debugger on the far side of the debug access port.
  Assumes the link is already decoded into one-cycle strobes on mclk.
*/
`timescale 1ns/1ps
module debugger_model (
  input  wire logic                        mclk,
  output      debug_mailbox_pkg::reg_req_t req,
  input  wire debug_mailbox_pkg::reg_rsp_t rsp
);
  import debug_mailbox_pkg::*;

  initial req = '0;

  // Released address and data are inverted so no stale value looks valid.
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    q = '0;
    @(posedge mclk);
    #1;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    for (n = 0; n < 4 && !w; n++) begin
      if (rsp.valid === 1'b1) begin
        q = rsp.data;
        break;
      end
      @(posedge mclk);
      #1;
    end
  endtask : xfer
endmodule : debugger_model

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the debug mailbox and dual-key unlock.
  Assumes both register ports share mclk and answer reads one cycle later.
*/
`timescale 1ns/1ps
module tb_top;
  import debug_mailbox_pkg::*;
  logic                 mclk = 1'b0;
  logic                 rst  = 1'b1;
  reg_req_t             dbg_req;
  reg_rsp_t             dbg_rsp;
  reg_req_t             cpu_req = '0;
  reg_rsp_t             cpu_rsp;
  logic                 full_wipe_start;
  logic                 key_write_lock;
  int                   bad_count = 0;
  int                   cmp_count = 0;
  int                   wipe_n = 0;
  logic [DATA_W-1:0]    q;
  logic [DATA_W-1:0]    w;
  logic                 sd;
  logic [DATA_W-1:0]    junk;
  logic [ADDR_W-1:0]    txw[2] = '{CPU_OUTBOUND_WORD_OFS, DBG_OUTBOUND_WORD_OFS};
  logic [ADDR_W-1:0]    txf[2] = '{CPU_OUTBOUND_FLAG_OFS, DBG_OUTBOUND_FLAG_OFS};
  logic [ADDR_W-1:0]    rxw[2] = '{CPU_INBOUND_WORD_OFS, DBG_INBOUND_WORD_OFS};
  logic [ADDR_W-1:0]    rxf[2] = '{CPU_INBOUND_FLAG_OFS, DBG_INBOUND_FLAG_OFS};

  always #5 mclk = ~mclk;
  always @(negedge mclk) if (full_wipe_start === 1'b1) wipe_n++;

  debugger_model i_dbg (.mclk(mclk), .req(dbg_req), .rsp(dbg_rsp));

  debug_mailbox_erase_unlock i_dut (
    .mclk(mclk), .rst(rst), .dbg_req(dbg_req), .dbg_rsp(dbg_rsp),
    .cpu_req(cpu_req), .cpu_rsp(cpu_rsp),
    .full_wipe_start(full_wipe_start), .key_write_lock(key_write_lock)
  );

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cpu_xfer(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    q = '0;
    @(posedge mclk);
    #1;
    cpu_req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    cpu_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    for (n = 0; n < 4 && !w; n++) begin
      if (cpu_rsp.valid === 1'b1) begin
        q = cpu_rsp.data;
        break;
      end
      @(posedge mclk);
      #1;
    end
  endtask : cpu_xfer

  // Side 1 is the debugger, side 0 the CPU.
  task automatic acc(input logic s, input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    if (s) i_dbg.xfer(wr, a, d, q);
    else cpu_xfer(wr, a, d, q);
  endtask : acc

  task automatic rd_chk(input logic s, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp);
    acc(s, 1'b0, a, '0);
    chk(q, exp);
  endtask : rd_chk

  task automatic do_reset;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
  endtask : do_reset

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  initial begin
    do_reset();
    rd_chk(1'b1, PORT_IDENT_OFS, PORT_IDENT_VALUE);
    acc(1'b1, 1'b1, PORT_IDENT_OFS, 32'h00000000);
    rd_chk(1'b1, PORT_IDENT_OFS, PORT_IDENT_VALUE);
    rd_chk(1'b1, 12'h100, 32'h00000000);
    for (int i = 0; i < 2; i++) begin
      sd = i[0];
      w = 32'hA5C30F00 | DATA_W'(i);
      acc(sd, 1'b1, txf[sd], 32'hFFFFFFFF);
      rd_chk(sd, txf[sd], 32'h00000000);
      acc(sd, 1'b1, txw[sd], w);
      rd_chk(sd, txf[sd], 32'h00000001);
      rd_chk(!sd, rxf[!sd], 32'h00000001);
      rd_chk(!sd, rxw[!sd], w);
      rd_chk(!sd, rxf[!sd], 32'h00000000);
      rd_chk(sd, txf[sd], 32'h00000000);
      // The receiver reads on the edge right after the sender's write.
      w = ~w;
      fork
        acc(sd, 1'b1, txw[sd], w);
        begin
          @(posedge mclk);
          acc(!sd, 1'b0, rxw[!sd], 32'h00000000);
        end
      join
      chk(q, w);
      rd_chk(sd, txf[sd], 32'h00000000);
      // A write and the consuming read on one edge: the new word stays waiting.
      fork
        if (sd) i_dbg.xfer(1'b1, txw[sd], ~w, junk);
        else cpu_xfer(1'b1, txw[sd], ~w, junk);
        acc(!sd, 1'b0, rxw[!sd], 32'h00000000);
      join
      chk(q, w);
      rd_chk(!sd, rxf[!sd], 32'h00000001);
      rd_chk(!sd, rxw[!sd], ~w);
      rd_chk(sd, txf[sd], 32'h00000000);
    end
    rd_chk(1'b0, CPU_KEY_LOCK_OFS, 32'h00000000);
    chk(DATA_W'(wipe_n), 32'h00000000);
    acc(1'b1, 1'b1, DBG_UNLOCK_KEY_OFS, 32'h13572468);
    acc(1'b0, 1'b1, CPU_UNLOCK_KEY_OFS, 32'h13572469);
    repeat (4) @(posedge mclk);
    chk(DATA_W'(wipe_n), 32'h00000000);
    acc(1'b0, 1'b1, CPU_UNLOCK_KEY_OFS, 32'h13572468);
    repeat (4) @(posedge mclk);
    chk(DATA_W'(wipe_n), 32'h00000001);
    acc(1'b0, 1'b1, CPU_KEY_LOCK_OFS, 32'hFFFFFFFE);
    rd_chk(1'b0, CPU_KEY_LOCK_OFS, 32'h00000000);
    acc(1'b0, 1'b1, CPU_KEY_LOCK_OFS, 32'h00000001);
    chk(DATA_W'(key_write_lock), 32'h00000001);
    acc(1'b0, 1'b1, CPU_UNLOCK_KEY_OFS, 32'h0BAD0BAD);
    rd_chk(1'b0, CPU_UNLOCK_KEY_OFS, 32'h13572468);
    acc(1'b0, 1'b1, CPU_KEY_LOCK_OFS, 32'h00000000);
    rd_chk(1'b0, CPU_KEY_LOCK_OFS, 32'h00000001);
    do_reset();
    chk(DATA_W'(key_write_lock), 32'h00000000);
    rd_chk(1'b0, CPU_UNLOCK_KEY_OFS, 32'h00000000);
    stop_test();
  end
endmodule : tb_top
